/* src/out_bank_pkg.sv */
// offsets, field layouts, reset values and driver codes of the output banks
package out_bank_pkg;
	localparam int unsigned PAIRS = 4;
	localparam int unsigned KIND_W = 3;

	localparam logic [3:0] OFS_A_TERM_POL = 4'h2;
	localparam logic [3:0] OFS_A_MODE_HI = 4'h3;
	localparam logic [3:0] OFS_A_MODE_LO = 4'h4;
	localparam logic [3:0] OFS_A_OFF = 4'h5;
	localparam logic [3:0] OFS_B_TERM = 4'h6;
	localparam logic [3:0] OFS_B_MODE_HI = 4'h7;
	localparam logic [3:0] OFS_B_MODE_LO = 4'h8;
	localparam logic [3:0] OFS_B_OFF = 4'h9;

	// field positions within an 8-bit register
	localparam int unsigned TERM_BIT = 4;
	localparam int unsigned POL_LSB = 0;
	localparam int unsigned MODE_HI_LSB = 3;
	localparam int unsigned MODE_LO_LSB = 0;
	localparam int unsigned OFF_LSB = 4;

	typedef enum logic [2:0] {
		KIND_HIZ = 3'h0,
		KIND_LVPECL = 3'h1,
		KIND_LVDS = 3'h2,
		KIND_LVCMOS = 3'h3,
		KIND_HCSL = 3'h4,
		KIND_CML400 = 3'h5,
		KIND_CML800 = 3'h6,
		KIND_RSVD = 3'h7
	} driver_kind_e;

	localparam logic [11:0] RST_MODES = {4{KIND_LVDS}};
	localparam logic [3:0] RST_POL = 4'h0;
	localparam logic [3:0] RST_OFF = 4'h0;
	localparam logic RST_TERM = 1'b0;
	localparam logic [7:0] RST_RDATA = 8'h00;
endpackage

/* src/out_bank_drive.sv */
// resolves one bank's stored settings into the driver configuration
`timescale 1ns/1ps
module out_bank_drive #(
	parameter bit HAS_CMOS = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [11:0] mode,
	input wire logic [3:0] off,
	input wire logic [3:0] pol,
	input wire logic sync_disable,
	output logic [11:0] drv_kind,
	output logic [3:0] pair_on,
	output logic [3:0] in_phase
);
	typedef struct packed {
		logic [11:0] kind;
		logic [3:0] on;
		logic [3:0] phase;
	} state_s;

	state_s state_reg;
	state_s state_next;

	always_comb begin
		logic [2:0] k;
		logic bad;
		k = 3'h0;
		bad = 1'b0;
		state_next = state_reg;
		for (int m = 0; m < 4; m++) begin
			k = mode[3*m +: 3];
			// reserved codes leave the pair quiet
			bad = (k == out_bank_pkg::KIND_RSVD) ||
				(!HAS_CMOS && k == out_bank_pkg::KIND_LVCMOS);
			// bank disable forces high impedance over any mode and off setting
			if (sync_disable || off[m] || bad) begin
				state_next.kind[3*m +: 3] = out_bank_pkg::KIND_HIZ;
				state_next.on[m] = 1'b0;
			end else begin
				state_next.kind[3*m +: 3] = k;
				state_next.on[m] = (k != out_bank_pkg::KIND_HIZ);
			end
			state_next.phase[m] = HAS_CMOS && pol[m] &&
				(k == out_bank_pkg::KIND_LVCMOS);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{kind: out_bank_pkg::RST_MODES, on: 4'hF,
				phase: 4'h0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign drv_kind = state_reg.kind;
	assign pair_on = state_reg.on;
	assign in_phase = state_reg.phase;
endmodule // out_bank_drive

/* src/out_bank_regs.sv */
// per-pair output configuration registers for both clock output banks
// How it works
// - codes 0 hi-z, 1 LVPECL, 2 LVDS, 3 LVCMOS, 4 HCSL, 5/6 CML, 7 rsvd
// - every pair's mode comes out of reset as code two, LVDS
// - first bank polarity bit: 0 inverted, 1 in phase, LVCMOS only, resets 0
// - each bank has an HCSL termination indicator, resets to zero
// - first bank pair off bit: 1 powers pair down, resets 0
// - second bank pair off bit: 1 powers pair down, resets 0
// - first bank at offsets 2..5: term/polarity, modes hi, modes lo, offs
// - second bank at offsets 6..9, same layout, polarity slots reserved
// - bank sync disable forces all pair drivers hi-z and off, else pairs follow off bits
`timescale 1ns/1ps
module out_bank_regs (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic first_bank_sync_disable,
	input wire logic second_bank_sync_disable,
	output logic [11:0] first_bank_pair_driver_kind,
	output logic [3:0] first_bank_pair_on,
	output logic [3:0] first_bank_pair_polarity,
	output logic first_bank_termination,
	output logic [11:0] second_bank_pair_driver_kind,
	output logic [3:0] second_bank_pair_on,
	output logic second_bank_termination
);
	typedef struct packed {
		logic term_a;
		logic [3:0] pol_a;
		logic [11:0] mode_a;
		logic [3:0] off_a;
		logic term_b;
		logic [11:0] mode_b;
		logic [3:0] off_b;
		logic [7:0] rdata;
	} state_s;

	state_s state_reg;
	state_s state_next;

	// write path and registered read-back
	always_comb begin
		state_next = state_reg;
		if (reg_wr) begin
			if (reg_addr == out_bank_pkg::OFS_A_TERM_POL) begin
				state_next.term_a = reg_wdata[out_bank_pkg::TERM_BIT];
				state_next.pol_a = reg_wdata[out_bank_pkg::POL_LSB +: 4];
			end else if (reg_addr == out_bank_pkg::OFS_A_MODE_HI) begin
				state_next.mode_a[11:6] =
					reg_wdata[out_bank_pkg::MODE_LO_LSB +: 6];
			end else if (reg_addr == out_bank_pkg::OFS_A_MODE_LO) begin
				state_next.mode_a[5:0] =
					reg_wdata[out_bank_pkg::MODE_LO_LSB +: 6];
			end else if (reg_addr == out_bank_pkg::OFS_A_OFF) begin
				state_next.off_a = reg_wdata[out_bank_pkg::OFF_LSB +: 4];
			end else if (reg_addr == out_bank_pkg::OFS_B_TERM) begin
				state_next.term_b = reg_wdata[out_bank_pkg::TERM_BIT];
			end else if (reg_addr == out_bank_pkg::OFS_B_MODE_HI) begin
				state_next.mode_b[11:6] =
					reg_wdata[out_bank_pkg::MODE_LO_LSB +: 6];
			end else if (reg_addr == out_bank_pkg::OFS_B_MODE_LO) begin
				state_next.mode_b[5:0] =
					reg_wdata[out_bank_pkg::MODE_LO_LSB +: 6];
			end else if (reg_addr == out_bank_pkg::OFS_B_OFF) begin
				state_next.off_b = reg_wdata[out_bank_pkg::OFF_LSB +: 4];
			end
		end
		if (reg_rd) begin
			// reserved positions read as zero
			if (reg_addr == out_bank_pkg::OFS_A_TERM_POL) begin
				state_next.rdata = {3'h0, state_reg.term_a, state_reg.pol_a};
			end else if (reg_addr == out_bank_pkg::OFS_A_MODE_HI) begin
				state_next.rdata = {2'h0, state_reg.mode_a[11:6]};
			end else if (reg_addr == out_bank_pkg::OFS_A_MODE_LO) begin
				state_next.rdata = {2'h0, state_reg.mode_a[5:0]};
			end else if (reg_addr == out_bank_pkg::OFS_A_OFF) begin
				state_next.rdata = {state_reg.off_a, 4'h0};
			end else if (reg_addr == out_bank_pkg::OFS_B_TERM) begin
				state_next.rdata = {3'h0, state_reg.term_b, 4'h0};
			end else if (reg_addr == out_bank_pkg::OFS_B_MODE_HI) begin
				state_next.rdata = {2'h0, state_reg.mode_b[11:6]};
			end else if (reg_addr == out_bank_pkg::OFS_B_MODE_LO) begin
				state_next.rdata = {2'h0, state_reg.mode_b[5:0]};
			end else if (reg_addr == out_bank_pkg::OFS_B_OFF) begin
				state_next.rdata = {state_reg.off_b, 4'h0};
			end else begin
				state_next.rdata = out_bank_pkg::RST_RDATA;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{term_a: out_bank_pkg::RST_TERM,
				pol_a: out_bank_pkg::RST_POL,
				mode_a: out_bank_pkg::RST_MODES,
				off_a: out_bank_pkg::RST_OFF,
				term_b: out_bank_pkg::RST_TERM,
				mode_b: out_bank_pkg::RST_MODES,
				off_b: out_bank_pkg::RST_OFF,
				rdata: out_bank_pkg::RST_RDATA};
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign first_bank_termination = state_reg.term_a;
	assign second_bank_termination = state_reg.term_b;

	// pairs re-enabled while the bank is sync-disabled start cleanly
	out_bank_drive #(.HAS_CMOS(1'b1)) bank_a (
		.sys_clk(sys_clk),
		.rst(rst),
		.mode(state_reg.mode_a),
		.off(state_reg.off_a),
		.pol(state_reg.pol_a),
		.sync_disable(first_bank_sync_disable),
		.drv_kind(first_bank_pair_driver_kind),
		.pair_on(first_bank_pair_on),
		.in_phase(first_bank_pair_polarity)
	);

	out_bank_drive #(.HAS_CMOS(1'b0)) bank_b (
		.sys_clk(sys_clk),
		.rst(rst),
		.mode(state_reg.mode_b),
		.off(state_reg.off_b),
		.pol(4'h0),
		.sync_disable(second_bank_sync_disable),
		.drv_kind(second_bank_pair_driver_kind),
		.pair_on(second_bank_pair_on),
		.in_phase()
	);
endmodule // out_bank_regs

/* verification/out_bank_props.sv */
// assertions on the ports of the output bank register block
`timescale 1ns/1ps
module out_bank_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic first_bank_sync_disable,
	input wire logic second_bank_sync_disable,
	input wire logic [11:0] first_bank_pair_driver_kind,
	input wire logic [3:0] first_bank_pair_on,
	input wire logic [3:0] first_bank_pair_polarity,
	input wire logic first_bank_termination,
	input wire logic [11:0] second_bank_pair_driver_kind,
	input wire logic [3:0] second_bank_pair_on,
	input wire logic second_bank_termination
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_hold_a; first_bank_sync_disable [*3]; endsequence
	sequence s_hold_b; second_bank_sync_disable [*3]; endsequence
	sequence s_off_a0;
		reg_wr && reg_addr == out_bank_pkg::OFS_A_OFF && reg_wdata[4];
	endsequence
	a_sync_a_off: assert property (s_hold_a |->
		first_bank_pair_driver_kind == 12'h000 && first_bank_pair_on == 4'h0)
		else $error("bank a active under sync disable");
	a_sync_b_off: assert property (s_hold_b |->
		second_bank_pair_driver_kind == 12'h000 && second_bank_pair_on == 4'h0)
		else $error("bank b active under sync disable");
	a_term_a_write: assert property (reg_wr && reg_addr == 4'h2 |=>
		first_bank_termination == $past(reg_wdata[4])) else $error("term a");
	a_term_b_write: assert property (reg_wr && reg_addr == 4'h6 |=>
		second_bank_termination == $past(reg_wdata[4])) else $error("term b");
	a_on_has_kind: assert property (first_bank_pair_on[0] |->
		first_bank_pair_driver_kind[2:0] != 3'h0) else $error("on with hi-z");
	a_b_no_cmos: assert property (second_bank_pair_on[0] |->
		second_bank_pair_driver_kind[2:0] != 3'h3) else $error("cmos in b");
	a_off_write: assert property (s_off_a0 |-> ##2
		!first_bank_pair_on[0]) else $error("pair off write not applied");
	a_unmapped_read: assert property (reg_rd &&
		(reg_addr < 4'h2 || reg_addr > 4'h9) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // out_bank_props
bind out_bank_regs out_bank_props u_props (.*);

/* verification/out_bank_regs_tb.sv */
// self-checking bench for the output bank register block
`timescale 1ns/1ps
module out_bank_regs_tb;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sda = 0, sdb = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [11:0] ka, kb;
	logic [3:0] oa, pa, ob;
	logic ta, tb;
	int n_fail = 0, n_checks = 0, cyc = 0;
	out_bank_regs DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .first_bank_sync_disable(sda),
		.second_bank_sync_disable(sdb), .first_bank_pair_driver_kind(ka),
		.first_bank_pair_on(oa), .first_bank_pair_polarity(pa),
		.first_bank_termination(ta), .second_bank_pair_driver_kind(kb),
		.second_bank_pair_on(ob), .second_bank_termination(tb));
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			end_sim;
		end
	end
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// write taken at the next edge; config visible one edge after that
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge sys_clk) #1 reg_wr = 0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1;
		@(posedge sys_clk) #1 reg_rd = 0;
		chk(reg_rdata, e);
		// idle edge so a following read never re-raises the strobe at once
		@(posedge sys_clk);
		#1;
	endtask
	task automatic t_reset;
		chk({ka, kb}, 24'h49_2492);
		chk({oa, ob, pa, ta, tb}, 24'h00_3fc0);
		for (int a = 2; a < 10; a++)
			rd(4'(a), (a % 4 == 3 || a % 4 == 0) ? 8'h12 : 8'h00);
		$display("test reset done");
	endtask
	task automatic t_modes;
		int ea, eb;
		for (int c = 0; c < 8; c++) begin
			ea = (c % 7 == 0) ? 0 : c;
			eb = (c == 3) ? 0 : ea;
			wr(4'h4, 8'(c * 9));
			wr(4'h8, 8'(c * 9));
			rd(4'h8, 8'(c * 9));
			chk({ka[5:0], kb[5:0], oa[1:0], ob[1:0]}, {6'(ea * 9), 6'(eb * 9),
				{2{ea != 0}}, {2{eb != 0}}});
		end
		$display("test modes done");
	endtask
	task automatic t_pol_off;
		wr(4'h3, 8'h1b);
		wr(4'h2, 8'h1f);
		wr(4'h6, 8'h10);
		chk({pa, ta, tb}, 24'h00_0033);
		rd(4'h6, 8'h10);
		wr(4'h5, 8'hb0);
		wr(4'h9, 8'h50);
		chk({oa, ob, ka}, 24'h04_80c0);
		rd(4'h9, 8'h50);
		$display("test polarity and off done");
	endtask
	task automatic t_sync;
		sda = 1;
		sdb = 1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({oa, ob, ka}, 24'h00_0000);
		chk({12'h000, kb}, 24'h00_0000);
		// pair three is switched back on only while its bank is held
		wr(4'h5, 8'h30);
		chk({oa, ob, ka}, 24'h00_0000);
		sda = 0;
		sdb = 0;
		wr(4'h0, 8'hf1);
		rd(4'ha, 8'h00);
		rd(4'h5, 8'h30);
		chk({oa, ob, ka}, 24'h0c_86c0);
		$display("test sync disable done");
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 rst = 0;
		@(posedge sys_clk);
		#1;
		t_reset;
		t_modes;
		t_pol_off;
		t_sync;
		end_sim;
	end
endmodule // out_bank_regs_tb
